// [hdl/uxc_pkg.sv]
// uxc_pkg: constants shared by the crossbar control block
// assumes one core clock; this file holds no logic
package uxc_pkg;
   // target address, upper five bits fixed
   localparam logic [4:0] ADDR_FIXED = 5'h15;
   // identification byte, value arbitrary
   localparam logic [7:0] ID_BYTE = 8'h5A;
   // selection byte layout and reset value
   localparam int SEL_W = 3;
   localparam logic [2:0] SEL_RST = 3'h1;
   // configuration codes
   localparam logic [2:0] CODE_OFF = 3'h0;
   localparam logic [2:0] CODE_IDLE = 3'h1;
   localparam logic [2:0] CODE_DP4 = 3'h2;
   localparam logic [2:0] CODE_DP4_FLIP = 3'h3;
   localparam logic [2:0] CODE_USB = 3'h4;
   localparam logic [2:0] CODE_USB_FLIP = 3'h5;
   localparam logic [2:0] CODE_DP2 = 3'h6;
   localparam logic [2:0] CODE_DP2_FLIP = 3'h7;
   // connector pair a system channel lands on
   localparam logic [2:0] DEST_OPEN = 3'h0;
   localparam logic [2:0] DEST_TX1 = 3'h1;
   localparam logic [2:0] DEST_TX2 = 3'h2;
   localparam logic [2:0] DEST_RX1 = 3'h3;
   localparam logic [2:0] DEST_RX2 = 3'h4;
   // sideband line an auxiliary member lands on
   localparam logic [1:0] SBU_OPEN = 2'h0;
   localparam logic [1:0] SBU_1 = 2'h1;
   localparam logic [1:0] SBU_2 = 2'h2;
   // system channels: usb tx, usb rx, lanes 0..3
   localparam int NCH = 6;
   // i2c byte bit count
   localparam logic [3:0] BITS_BYTE = 4'h8;
   // target states, one-hot
   typedef enum logic [6:0] {
      ST_IDLE = 7'h01,
      ST_ADDR = 7'h02,
      ST_AACK = 7'h04,
      ST_WR = 7'h08,
      ST_WACK = 7'h10,
      ST_RD = 7'h20,
      ST_RACK = 7'h40
   } uxc_state_t;
endpackage

// [hdl/uxc_route_decode.sv]
// uxc_route_decode: configuration code to switch routing
// assumes a stable code and placement from the caller's flops
`timescale 1ns/1ns
`default_nettype none
module uxc_route_decode
(
   // selection
   input wire logic [2:0] code,
   input wire logic sink,
   // routing
   output logic [3*uxc_pkg::NCH-1:0] dest,
   output logic [1:0] aux_p_dest,
   output logic [1:0] aux_n_dest,
   output logic power_down
);
   // flip swaps group 1 and group 2
   function automatic logic [2:0] grp(input logic [2:0] d, input logic flip);
      logic [2:0] r;
      r = d;
      if (flip)
      begin
         unique case (d)
            uxc_pkg::DEST_TX1: r = uxc_pkg::DEST_TX2;
            uxc_pkg::DEST_TX2: r = uxc_pkg::DEST_TX1;
            uxc_pkg::DEST_RX1: r = uxc_pkg::DEST_RX2;
            uxc_pkg::DEST_RX2: r = uxc_pkg::DEST_RX1;
            default: r = d;
         endcase
      end
      return r;
   endfunction

   wire logic flip = code[0];
   wire logic usb_on = code[2];
   wire logic dp_on = code[1];
   wire logic dp4 = (code[2:1] == 2'b01);
   wire logic [2:0] l0 = sink ? uxc_pkg::DEST_TX2 : uxc_pkg::DEST_RX2;
   wire logic [2:0] l1 = sink ? uxc_pkg::DEST_RX2 : uxc_pkg::DEST_TX2;
   wire logic [2:0] l2 = sink ? uxc_pkg::DEST_RX1 : uxc_pkg::DEST_TX1;
   wire logic [2:0] l3 = sink ? uxc_pkg::DEST_TX1 : uxc_pkg::DEST_RX1;
   wire logic [1:0] ap = (sink ^ flip) ? uxc_pkg::SBU_2 : uxc_pkg::SBU_1;
   wire logic [1:0] an = (sink ^ flip) ? uxc_pkg::SBU_1 : uxc_pkg::SBU_2;

   always_comb
   begin
      dest = '0;
      aux_p_dest = uxc_pkg::SBU_OPEN;
      aux_n_dest = uxc_pkg::SBU_OPEN;
      power_down = (code == uxc_pkg::CODE_OFF);
      if (usb_on)
      begin
         dest[2:0] = grp(uxc_pkg::DEST_TX1, flip);
         dest[5:3] = grp(uxc_pkg::DEST_RX1, flip);
      end
      if (dp_on)
      begin
         dest[8:6] = grp(l0, flip);
         dest[11:9] = grp(l1, flip);
         aux_p_dest = ap;
         aux_n_dest = an;
      end
      if (dp4)
      begin
         dest[14:12] = grp(l2, flip);
         dest[17:15] = grp(l3, flip);
      end
   end
endmodule // uxc_route_decode
`default_nettype wire

// [hdl/uxc_xbar_ctrl.sv]
// uxc_xbar_ctrl: control of a usb-c alternate-mode crossbar
// assumes pins and i2c lines are asynchronous to core_clk
`timescale 1ns/1ns
`default_nettype none
// Overview of operation
// - strap picks pin code or i2c control
// - address 10101, two pin bits, direction bit
// - identification byte read only, writes ignored
// - selection byte holds code, upper bits zero
// - pin and register codes decode identically
// - 000 open and off, 001 open powered
// - 100/101 usb to group 1/2 only
// - source four-lane mapping, flip reverses
// - source two-lane plus usb mapping
// - sink four-lane mapping, flip reverses
// - sink two-lane plus usb mapping
// - whole differential pair switches together
module uxc_xbar_ctrl
(
   // clock and reset
   input wire logic core_clk,
   input wire logic rstn,
   // straps and pins
   input wire logic control_source_select,
   input wire logic bus_level_select,
   input wire logic [2:0] crossbar_config_code,
   input wire logic target_addr_bit_hi,
   input wire logic target_addr_bit_lo,
   input wire logic sink_placement,
   // i2c target
   input wire logic scl,
   input wire logic sda_in,
   output logic sda_out,
   output logic sda_oe,
   // switch network
   output logic [3*uxc_pkg::NCH-1:0] chan_dest,
   output logic [uxc_pkg::NCH-1:0] close_p,
   output logic [uxc_pkg::NCH-1:0] close_n,
   output logic [1:0] aux_p_dest,
   output logic [1:0] aux_n_dest,
   output logic power_down,
   output logic io_level_3v3
);
   // two-flop synchronisers for every pin
   localparam int NS = 11;
   logic [NS-1:0] meta_r, sync_r;
   logic scl_d_r, sda_d_r;
   wire logic [NS-1:0] pin_in = {control_source_select, bus_level_select, crossbar_config_code,
      target_addr_bit_hi, target_addr_bit_lo, sink_placement, scl, sda_in, 1'b0};
   wire logic i2c_mode = sync_r[10];
   wire logic [2:0] pin_code = sync_r[8:6];
   wire logic [1:0] addr_pins = sync_r[5:4];
   wire logic sink_s = sync_r[3];
   wire logic scl_s = sync_r[2];
   wire logic sda_s = sync_r[1];
   // bus lines reset to their idle high, so no false edge after reset
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         meta_r <= 11'h006;
         sync_r <= 11'h006;
         scl_d_r <= 1'b1;
         sda_d_r <= 1'b1;
      end
      else
      begin
         meta_r <= pin_in;
         sync_r <= meta_r;
         scl_d_r <= scl_s;
         sda_d_r <= sda_s;
      end
   end
   // bus edges
   wire logic scl_rise = scl_s & ~scl_d_r;
   wire logic scl_fall = ~scl_s & scl_d_r;
   wire logic start_c = scl_s & scl_d_r & sda_d_r & ~sda_s;
   wire logic stop_c = scl_s & scl_d_r & ~sda_d_r & sda_s;
   // i2c target state
   uxc_pkg::uxc_state_t state_r, state_nxt;
   logic [3:0] cnt_r, cnt_nxt;
   logic [7:0] sh_r, sh_nxt;
   logic rw_r, rw_nxt, idx_r, idx_nxt, oe_r, oe_nxt;
   logic [2:0] sel_r, sel_nxt;
   wire logic [6:0] my_addr = {uxc_pkg::ADDR_FIXED, addr_pins};
   wire logic addr_hit = (sh_r[7:1] == my_addr);
   wire logic [7:0] rd_byte = idx_r ? {5'h00, sel_r} : uxc_pkg::ID_BYTE;
   wire logic byte_done = (cnt_r == uxc_pkg::BITS_BYTE);
   always_comb
   begin
      state_nxt = state_r;
      cnt_nxt = cnt_r;
      sh_nxt = sh_r;
      rw_nxt = rw_r;
      idx_nxt = idx_r;
      oe_nxt = oe_r;
      sel_nxt = sel_r;
      if (!i2c_mode || stop_c)
      begin
         state_nxt = uxc_pkg::ST_IDLE;
         oe_nxt = 1'b0;
      end
      else if (start_c)
      begin
         state_nxt = uxc_pkg::ST_ADDR;
         cnt_nxt = 4'h0;
         oe_nxt = 1'b0;
      end
      else
      begin
         unique case (state_r)
            uxc_pkg::ST_IDLE: ;
            uxc_pkg::ST_ADDR, uxc_pkg::ST_WR:
               if (scl_rise)
               begin
                  sh_nxt = {sh_r[6:0], sda_s};
                  cnt_nxt = cnt_r + 4'h1;
               end
               else if (scl_fall && byte_done)
               begin
                  if (state_r == uxc_pkg::ST_WR)
                  begin
                     if (idx_r)
                        sel_nxt = sh_r[uxc_pkg::SEL_W-1:0];
                     idx_nxt = 1'b1;
                     state_nxt = uxc_pkg::ST_WACK;
                     oe_nxt = 1'b1;
                  end
                  else if (addr_hit)
                  begin
                     rw_nxt = sh_r[0];
                     idx_nxt = 1'b0;
                     state_nxt = uxc_pkg::ST_AACK;
                     oe_nxt = 1'b1;
                  end
                  else
                     state_nxt = uxc_pkg::ST_IDLE;
               end
            uxc_pkg::ST_AACK, uxc_pkg::ST_WACK, uxc_pkg::ST_RACK:
               if (scl_rise && state_r == uxc_pkg::ST_RACK && sda_s)
                  state_nxt = uxc_pkg::ST_IDLE;
               else if (scl_fall && (state_r == uxc_pkg::ST_RACK || rw_r))
               begin
                  state_nxt = uxc_pkg::ST_RD;
                  sh_nxt = rd_byte;
                  oe_nxt = ~rd_byte[7];
                  cnt_nxt = 4'h1;
               end
               else if (scl_fall)
               begin
                  state_nxt = uxc_pkg::ST_WR;
                  oe_nxt = 1'b0;
                  cnt_nxt = 4'h0;
               end
            uxc_pkg::ST_RD:
               if (scl_fall && byte_done)
               begin
                  state_nxt = uxc_pkg::ST_RACK;
                  oe_nxt = 1'b0;
                  idx_nxt = 1'b1;
               end
               else if (scl_fall)
               begin
                  sh_nxt = {sh_r[6:0], 1'b0};
                  oe_nxt = ~sh_r[6];
                  cnt_nxt = cnt_r + 4'h1;
               end
            default:
               state_nxt = uxc_pkg::ST_IDLE;
         endcase
      end
   end
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         state_r <= uxc_pkg::ST_IDLE;
         cnt_r <= 4'h0;
         sh_r <= 8'h00;
         rw_r <= 1'b0;
         idx_r <= 1'b0;
         oe_r <= 1'b0;
         sel_r <= uxc_pkg::SEL_RST;
      end
      else
      begin
         state_r <= state_nxt;
         cnt_r <= cnt_nxt;
         sh_r <= sh_nxt;
         rw_r <= rw_nxt;
         idx_r <= idx_nxt;
         oe_r <= oe_nxt;
         sel_r <= sel_nxt;
      end
   end
   assign sda_oe = oe_r;
   assign sda_out = 1'b0;
   // active code and switch network
   logic [2:0] code_r;
   logic sink_r;
   wire logic [2:0] code_nxt = i2c_mode ? sel_r : pin_code;
   wire logic [3*uxc_pkg::NCH-1:0] dec_dest;
   wire logic [1:0] dec_ap, dec_an;
   wire logic dec_pd;
   uxc_route_decode u_dec
   (
      .code(code_r),
      .sink(sink_r),
      .dest(dec_dest),
      .aux_p_dest(dec_ap),
      .aux_n_dest(dec_an),
      .power_down(dec_pd)
   );
   wire logic [uxc_pkg::NCH-1:0] dec_close;
   genvar g;
   generate
      for (g = 0; g < uxc_pkg::NCH; g++)
      begin : g_close
         assign dec_close[g] = (dec_dest[3*g +: 3] != uxc_pkg::DEST_OPEN);
      end
   endgenerate
   always_ff @(posedge core_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         code_r <= uxc_pkg::CODE_OFF;
         sink_r <= 1'b0;
         chan_dest <= '0;
         close_p <= '0;
         close_n <= '0;
         aux_p_dest <= uxc_pkg::SBU_OPEN;
         aux_n_dest <= uxc_pkg::SBU_OPEN;
         power_down <= 1'b1;
         io_level_3v3 <= 1'b0;
      end
      else
      begin
         code_r <= code_nxt;
         sink_r <= sink_s;
         chan_dest <= dec_dest;
         close_p <= dec_close;
         close_n <= dec_close;
         aux_p_dest <= dec_ap;
         aux_n_dest <= dec_an;
         power_down <= dec_pd;
         io_level_3v3 <= sync_r[9];
      end
   end
   // checks
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!rstn);
   chk_pin_mode_code: assert property (!i2c_mode |=> code_r == $past(pin_code))
      else $error("pin mode code not taken");
   chk_addr_miss_drop: assert property (state_r == uxc_pkg::ST_ADDR && scl_fall && byte_done
      && !addr_hit && i2c_mode |=> state_r == uxc_pkg::ST_IDLE && !sda_oe)
      else $error("foreign address acknowledged");
   chk_id_first_byte: assert property (state_r == uxc_pkg::ST_AACK && rw_r && scl_fall
      && i2c_mode && !start_c && !stop_c |=> sh_r == uxc_pkg::ID_BYTE)
      else $error("read does not start with identification");
   chk_sel_upper_zero: assert property (state_r == uxc_pkg::ST_RACK && scl_fall && i2c_mode
      |=> sh_r[7:3] == 5'h00)
      else $error("selection upper bits not zero");
   chk_write_commit: assert property (state_r == uxc_pkg::ST_WACK && idx_r && i2c_mode
      |=> ##2 code_r == sel_r)
      else $error("written selection not applied");
   chk_open_codes: assert property (code_r == uxc_pkg::CODE_IDLE
      |=> !power_down && close_p == '0 && aux_p_dest == uxc_pkg::SBU_OPEN)
      else $error("open powered code wrong");
   chk_off_code: assert property (code_r == uxc_pkg::CODE_OFF |=> power_down && close_n == '0)
      else $error("power down code wrong");
   chk_usb_only: assert property (code_r == uxc_pkg::CODE_USB_FLIP |=> close_p[5:2] == 4'h0
      && chan_dest[2:0] == uxc_pkg::DEST_TX2 && chan_dest[5:3] == uxc_pkg::DEST_RX2)
      else $error("usb only routing wrong");
   chk_dp4_source: assert property (code_r == uxc_pkg::CODE_DP4 && !sink_r
      |=> chan_dest[8:6] == uxc_pkg::DEST_RX2 && chan_dest[17:15] == uxc_pkg::DEST_RX1
      && aux_p_dest == uxc_pkg::SBU_1 && close_p[1:0] == 2'h0)
      else $error("source four-lane routing wrong");
   chk_dp2_source: assert property (code_r == uxc_pkg::CODE_DP2_FLIP && !sink_r
      |=> chan_dest[2:0] == uxc_pkg::DEST_TX2 && chan_dest[8:6] == uxc_pkg::DEST_RX1
      && aux_n_dest == uxc_pkg::SBU_1 && close_p[5:4] == 2'h0)
      else $error("source two-lane routing wrong");
   chk_dp4_sink: assert property (code_r == uxc_pkg::CODE_DP4_FLIP && sink_r
      |=> chan_dest[8:6] == uxc_pkg::DEST_TX1 && chan_dest[14:12] == uxc_pkg::DEST_RX2
      && aux_p_dest == uxc_pkg::SBU_1)
      else $error("sink four-lane routing wrong");
   chk_dp2_sink: assert property (code_r == uxc_pkg::CODE_DP2 && sink_r
      |=> chan_dest[11:9] == uxc_pkg::DEST_RX2 && aux_p_dest == uxc_pkg::SBU_2
      && chan_dest[5:3] == uxc_pkg::DEST_RX1)
      else $error("sink two-lane routing wrong");
   chk_pair_together: assert property (close_p == close_n && |close_p == |chan_dest)
      else $error("pair members differ");
   cov_write_sel: cover property (state_r == uxc_pkg::ST_WACK && idx_r);
   cov_read_sel: cover property (state_r == uxc_pkg::ST_RD && idx_r);
   cov_dp4_sink: cover property (code_r == uxc_pkg::CODE_DP4 && sink_r);
endmodule // uxc_xbar_ctrl
`default_nettype wire

// [tb/tb.sv]
// tb: self-checking bench for the crossbar control block
// assumes the pd controller model drives the i2c side
`timescale 1ns/1ns
`default_nettype none
module tb;
   logic core_clk, rstn, cs, bl, hi, lo, sink, sda_out, sda_oe, pwr_dn, io3, scl, sda_pull;
   logic [2:0] pins;
   logic [3*uxc_pkg::NCH-1:0] chan_dest;
   logic [uxc_pkg::NCH-1:0] close_p, close_n;
   logic [1:0] aux_p, aux_n;
   wire logic sda_line;
   int err_count, cmp_count, sel, seed;
   int base[2][4] = '{'{4, 2, 1, 3}, '{2, 4, 3, 1}};
   assign sda_line = ~sda_pull & (sda_oe ? sda_out : 1'b1);
   uxc_xbar_ctrl dut (.core_clk(core_clk), .rstn(rstn), .control_source_select(cs),
      .bus_level_select(bl), .crossbar_config_code(pins), .target_addr_bit_hi(hi),
      .target_addr_bit_lo(lo), .sink_placement(sink), .scl(scl), .sda_in(sda_line),
      .sda_out(sda_out), .sda_oe(sda_oe), .chan_dest(chan_dest), .close_p(close_p),
      .close_n(close_n), .aux_p_dest(aux_p), .aux_n_dest(aux_n), .power_down(pwr_dn),
      .io_level_3v3(io3));
   uxc_pd_ctrl_model pd (.core_clk(core_clk), .sda_line(sda_line), .scl(scl),
      .sda_pull(sda_pull));
   task automatic cycles(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         err_count++;
         $display("[ERR] %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic wrap_up();
      if (err_count == 0 && cmp_count > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   // connector flip: group 1 and 2 trade places
   function automatic int gsw(input int g);
      return (g == 0) ? 0 : (g % 2 == 1) ? g + 1 : g - 1;
   endfunction
   task automatic chk_route(input int c);
      int f, v, d, ap, an;
      logic [17:0] ed;
      logic [5:0] ec;
      f = c % 2;
      v = (c == 2 || c == 3 || c >= 6);
      ed = '0;
      ec = '0;
      for (int ch = 0; ch < 6; ch++)
      begin
         d = 0;
         if (ch < 2 && c >= 4)
            d = (ch == 0) ? 1 : 3;
         if (ch >= 2 && v != 0 && (ch < 4 || c < 4))
            d = base[sink][ch - 2];
         if (f == 1)
            d = gsw(d);
         ed[3*ch +: 3] = d[2:0];
         ec[ch] = (d != 0);
      end
      ap = (v != 0) ? (sink ? 2 : 1) : 0;
      an = (v != 0) ? 3 - ap : 0;
      if (v != 0 && f == 1)
      begin
         ap = 3 - ap;
         an = 3 - an;
      end
      chk("chan_dest", chan_dest, ed);
      chk("close_p", close_p, ec);
      chk("close_n", close_n, ec);
      chk("aux_p", aux_p, ap);
      chk("aux_n", aux_n, an);
      chk("power_down", pwr_dn, c == 0);
   endtask
   task automatic wr(input logic [7:0] idv, input logic [7:0] sv);
      logic [7:0] q;
      logic a;
      pd.addr(hi, lo, 1'b0, a);
      chk("addr_ack", a, 1'b1);
      pd.xfer(idv, 1'b1, q, a);
      pd.xfer(sv, 1'b1, q, a);
      chk("data_ack", a, 1'b1);
      pd.stop();
   endtask
   task automatic rd();
      logic [7:0] q;
      logic a;
      pd.addr(hi, lo, 1'b1, a);
      chk("addr_ack", a, 1'b1);
      pd.xfer(8'hff, 1'b0, q, a);
      chk("id_byte", q, uxc_pkg::ID_BYTE);
      pd.xfer(8'hff, 1'b1, q, a);
      chk("sel_byte", q, sel);
      pd.stop();
   endtask
   initial
   begin
      core_clk = 1'b0;
      forever #10 core_clk = ~core_clk;
   end
   initial
   begin
      cycles(100000);
      err_count++;
      wrap_up();
   end
   initial
   begin : main
      logic [31:0] r;
      logic [7:0] q;
      logic a;
      rstn = 1'b0;
      {cs, bl, hi, lo, sink} = '0;
      pins = '0;
      err_count = 0;
      cmp_count = 0;
      seed = $urandom(32'ha0a2);
      cycles(8);
      rstn <= 1'b1;
      // pin mode, every code in both placements
      for (int s = 0; s < 2; s++)
      begin
         for (int c = 0; c < 8; c++)
         begin
            sink <= s[0];
            pins <= c[2:0];
            cycles(6);
            chk_route(c);
         end
      end
      r = $urandom;
      bl <= r[0];
      hi <= r[1];
      lo <= r[2];
      cs <= 1'b1;
      cycles(10);
      chk("io_level", io3, bl);
      sel = 1;
      rd();
      // every code through the register, pins wandering meanwhile
      for (int c = 7; c >= 0; c--)
      begin
         r = $urandom;
         sink <= r[0];
         pins <= r[3:1];
         wr(r[15:8], {r[20:16], c[2:0]});
         sel = c;
         cycles(6);
         chk_route(sel);
         rd();
      end
      // another target address: no ack, selection kept
      pd.addr(~hi, lo, 1'b0, a);
      chk("foreign_ack", a, 1'b0);
      pd.xfer(8'h00, 1'b1, q, a);
      pd.stop();
      cycles(6);
      chk_route(sel);
      cs <= 1'b0;
      pins <= 3'h6;
      cycles(6);
      chk_route(6);
      // pin mode: bus traffic ignored, pin routing kept
      pd.addr(hi, lo, 1'b0, a);
      chk("pin_mode_ack", a, 1'b0);
      pd.xfer(8'h00, 1'b1, q, a);
      pd.xfer(8'h07, 1'b1, q, a);
      pd.stop();
      cycles(6);
      chk_route(6);
      wrap_up();
   end
endmodule // tb
`default_nettype wire

// [tb/uxc_pd_ctrl_model.sv]
// uxc_pd_ctrl_model: i2c controller standing in for the pd controller
// assumes the bench resolves open-drain sda with a pull-up
`timescale 1ns/1ns
`default_nettype none
module uxc_pd_ctrl_model
(
   // clock
   input wire logic core_clk,
   // i2c lines
   input wire logic sda_line,
   output logic scl,
   output logic sda_pull
);
   initial
   begin
      scl = 1'b1;
      sda_pull = 1'b0;
   end
   task automatic hold(input int n);
      repeat (n) @(posedge core_clk);
   endtask
   // one bit, about ten core cycles per scl phase
   task automatic bit_x(input logic b, output logic s);
      hold(1);
      sda_pull <= ~b;
      hold(5);
      scl <= 1'b1;
      hold(9);
      s = sda_line;
      hold(1);
      scl <= 1'b0;
      hold(4);
   endtask
   task automatic start();
      hold(1);
      sda_pull <= 1'b0;
      hold(5);
      scl <= 1'b1;
      hold(10);
      sda_pull <= 1'b1;
      hold(10);
      scl <= 1'b0;
      hold(4);
   endtask
   task automatic stop();
      hold(1);
      sda_pull <= 1'b1;
      hold(5);
      scl <= 1'b1;
      hold(10);
      sda_pull <= 1'b0;
      hold(10);
   endtask
   // msb first, then the ack slot; rel high leaves the slot to the target
   task automatic xfer(input logic [7:0] d, input logic rel, output logic [7:0] q,
                       output logic ack);
      logic a;
      for (int i = 7; i >= 0; i--)
      begin
         bit_x(d[i], q[i]);
      end
      bit_x(rel, a);
      ack = ~a;
   endtask
   task automatic addr(input logic hi, input logic lo, input logic rw, output logic ack);
      logic [7:0] q;
      start();
      xfer({5'h15, hi, lo, rw}, 1'b1, q, ack);
   endtask
endmodule // uxc_pd_ctrl_model
`default_nettype wire
